/* rtl/ebr_pkg.sv */
package ebr_pkg;
  // Command bytes
  localparam logic [7:0] CLA_ENC      = 8'h04;
  localparam logic [7:0] CLA_REC      = 8'hC0;
  localparam logic [7:0] INS_BIN      = 8'hB0;
  localparam logic [7:0] INS_REC      = 8'hB2;
  // Length limits and block size
  localparam logic [7:0] LE_MIN       = 8'h08;
  localparam logic [7:0] LE_MAX       = 8'hE8;
  localparam int         BLK_BYTES    = 8;
  localparam logic [2:0] BLK_LAST     = 3'h7;
  // Record selection modes
  localparam logic [7:0] P2_ABS       = 8'h04;
  localparam logic [7:0] P2_CUR_MAX   = 8'h03;
  // Key nibble position within the creation byte
  localparam int         KEY_MSB      = 7;
  localparam int         KEY_LSB      = 4;
  // Status words
  localparam logic [15:0] SW_OK       = 16'h9000;
  localparam logic [15:0] SW_INVAL    = 16'h6283;
  localparam logic [15:0] SW_LEN      = 16'h6700;
  localparam logic [7:0]  SW1_WRONGLE = 8'h6C;
  localparam logic [15:0] SW_NOKEY    = 16'h6981;
  localparam logic [15:0] SW_ACFAIL   = 16'h6982;
  localparam logic [15:0] SW_BLOCKED  = 16'h6983;
  localparam logic [15:0] SW_DFSEL    = 16'h6986;
  localparam logic [15:0] SW_WRONGEF  = 16'h6A80;
  localparam logic [15:0] SW_OFFSET   = 16'h6B00;
  localparam logic [15:0] SW_INS      = 16'h6D00;
  localparam logic [15:0] SW_CLA      = 16'h6E00;
  localparam logic [15:0] SW_FAULT    = 16'h6F00;
  // Response buffer shape
  localparam int          FIFO_W      = 8;
  localparam int          FIFO_DEPTH  = 16;

  // Kind of the current selection
  typedef enum logic [1:0] {
    FILE_DF     = 2'b00,
    FILE_TRANSP = 2'b01,
    FILE_LINEAR = 2'b10,
    FILE_CYCLIC = 2'b11
  } ebr_file_type;

  // Access condition of the command in the selected file
  typedef enum logic [1:0] {
    ACCESS_ALWAYS   = 2'b00,
    ACCESS_NEVER    = 2'b01,
    ACCESS_KEY_AUTH = 2'b10,
    ACCESS_PROT     = 2'b11
  } ebr_access_type;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_FETCH  = 3'b010,
    ST_CIPHER = 3'b011,
    ST_PUSH   = 3'b100,
    ST_DRAIN  = 3'b101,
    ST_STATUS = 3'b110
  } ebr_state_type;
endpackage

/* rtl/ebr_fifo.sv */
`timescale 1ns/1ps
module ebr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;    // Storage
    logic [AW-1:0]           wr;     // Write pointer
    logic [AW-1:0]           rd;     // Read pointer
    logic [AW:0]             cnt;    // Fill level
    logic                    full;   // Registered full flag
    logic                    avail;  // Registered not-empty flag
    logic [W-1:0]            head;   // Registered oldest word
  } ebr_fifo_type;

  ebr_fifo_type s_q;  // Present state
  ebr_fifo_type s_d;  // Next state
  logic         push; // Accepted write
  logic         pop;  // Accepted read
  logic [AW:0]  cnt_n; // Level after this cycle

  // Flags and head word are flops so both handshakes see clean levels
  assign in_ready_o  = ~s_q.full;
  assign out_valid_o = s_q.avail;
  assign out_data_o  = s_q.head;

  // Next state
  always_comb begin
    s_d   = s_q;
    push  = in_valid_i & ~s_q.full;
    pop   = out_ready_i & s_q.avail;
    cnt_n = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      s_d.mem[s_q.wr] = in_data_i;
      s_d.wr          = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.cnt   = cnt_n;
    s_d.full  = (cnt_n == (AW+1)'(DEPTH));
    s_d.avail = (cnt_n != '0);
    // Head follows the updated array, so a word pushed into an empty queue shows at once
    s_d.head  = s_d.mem[s_d.rd];
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* rtl/ebr_cmd.sv */
`timescale 1ns/1ps
// Overview of operation
// - Enciphered read serves transparent files only
// - Dedicated file selected gives 6986
// - Linear or cyclic file gives 6A80
// - Unmet access: 6982 invalid key, 6983 blocked
// - Missing key file or key gives 6981
// - Protected mode never authorises this read
// - Key number from creation byte upper nibble
// - Key number shown in directory byte nibble
// - P1 high, P2 low, zero-based offset
// - Bad length granularity or range gives 6700
// - Offset beyond file end gives 6B00
// - Invalidated file gives 6283
// - Unknown instruction 6D00, wrong class 6E00
// - Internal fault gives 6F00
// - Success: enciphered data then 9000
// - USB mode length mismatch gives 6CYY
// - Record read only for linear or cyclic
// - Record read refused on invalidated file
// - P2 04 absolute, 00 to 03 current
module ebr_cmd
  import ebr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Command header
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_cla_i,
  input  wire logic [7:0]  cmd_ins_i,
  input  wire logic [7:0]  cmd_p1_i,
  input  wire logic [7:0]  cmd_p2_i,
  input  wire logic [7:0]  cmd_le_i,
  output logic             cmd_ready_o,
  // Transport mode
  input  wire logic        usb_mode_i,
  input  wire logic [7:0]  usb_xfer_len_i,
  // Selected file context
  input  wire logic [1:0]  file_type_i,
  input  wire logic        file_invalid_i,
  input  wire logic [15:0] file_size_i,
  input  wire logic [1:0]  access_condition_i,
  input  wire logic [7:0]  create_byte10_i,
  input  wire logic        key_file_present_i,
  input  wire logic        key_present_i,
  input  wire logic        key_authenticated_condition_i,
  input  wire logic        key_blocked_i,
  input  wire logic        fault_i,
  // Directory listing
  output logic [3:0]       dir_key_num_o,
  // File data memory
  output logic             mem_rd_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  // Cipher engine
  output logic             ciph_start_o,
  output logic [3:0]       ciph_key_num_o,
  output logic [63:0]      ciph_block_o,
  input  wire logic        ciph_done_i,
  input  wire logic [63:0] ciph_result_i,
  // Response data stream
  output logic             resp_valid_o,
  output logic [7:0]       resp_data_o,
  input  wire logic        resp_ready_i,
  // Status word
  output logic             sw_valid_o,
  output logic [15:0]      sw_o,
  // Record read hand-off
  output logic             rec_start_o,
  output logic             rec_absolute_o,
  output logic [1:0]       rec_cur_mode_o,
  output logic [7:0]       rec_number_o
);

  typedef struct packed {
    ebr_state_type st;      // Sequencer state
    logic          rdy;     // Idle and accepting
    logic [15:0]   addr;    // Next file byte address
    logic [7:0]    left;    // Bytes still to send
    logic [63:0]   blk;     // Plain or ciphered block
    logic [2:0]    idx;     // Byte within block
    logic [1:0]    ph;      // Memory read phase
    logic          rd;      // Memory read strobe
    logic          cstart;  // Cipher start pulse
    logic [3:0]    key;     // Cipher key number
    logic [3:0]    dkey;    // Directory key nibble
    logic          swv;     // Status valid pulse
    logic [15:0]   sw;      // Status word
    logic          rst;     // Record start pulse
    logic          rabs;    // Absolute record mode
    logic [1:0]    rmode;   // Current record mode
    logic [7:0]    rnum;    // Record number
    logic [7:0]    cla;     // Latched class
    logic [7:0]    ins;     // Latched instruction
    logic [7:0]    p1;      // Latched P1
    logic [7:0]    p2;      // Latched P2
    logic [7:0]    le;      // Latched length
  } ebr_cmd_type;

  ebr_cmd_type s_q;        // Present state
  ebr_cmd_type s_d;        // Next state
  logic [7:0]  cla_q;      // Latched class
  logic [7:0]  ins_q;      // Latched instruction
  logic [7:0]  p1_q;       // Latched P1
  logic [7:0]  p2_q;       // Latched P2
  logic [7:0]  le_q;       // Latched length
  logic [15:0] chk_sw;     // First failing status
  logic        chk_fail;   // Some check failed
  logic [15:0] offset;     // Requested start offset
  logic [16:0] end_addr;   // Offset plus length
  logic        fifo_valid; // Byte offered to buffer
  logic        fifo_ready; // Buffer has room
  logic        fifo_out_v; // Buffer holds data

  // Header bytes live in the state record; short names for the checks
  assign cla_q = s_q.cla;
  assign ins_q = s_q.ins;
  assign p1_q  = s_q.p1;
  assign p2_q  = s_q.p2;
  assign le_q  = s_q.le;

  // Offset is big-endian, counted from byte zero
  assign offset   = {p1_q, p2_q};
  assign end_addr = {1'b0, offset} + {9'h000, le_q};

  // Ordered checks; the earliest failure wins, but a fault overrides them all
  always_comb begin
    chk_sw = SW_OK;
    if (cla_q != CLA_ENC && cla_q != CLA_REC) begin
      chk_sw = SW_CLA;
    end else if (ins_q != INS_BIN && ins_q != INS_REC) begin
      chk_sw = SW_INS;
    end else if ((ins_q == INS_BIN) != (cla_q == CLA_ENC)) begin
      chk_sw = SW_CLA;
    end else if (file_type_i == FILE_DF) begin
      chk_sw = SW_DFSEL;
    end else if (ins_q == INS_BIN && file_type_i != FILE_TRANSP) begin
      chk_sw = SW_WRONGEF;
    end else if (ins_q == INS_REC && file_type_i == FILE_TRANSP) begin
      chk_sw = SW_WRONGEF;
    end else if (file_invalid_i) begin
      chk_sw = SW_INVAL;
    end else if (access_condition_i == ACCESS_PROT || access_condition_i == ACCESS_NEVER) begin
      chk_sw = SW_ACFAIL;
    end else if (access_condition_i == ACCESS_KEY_AUTH && (!key_file_present_i || !key_present_i)) begin
      chk_sw = SW_NOKEY;
    end else if (access_condition_i == ACCESS_KEY_AUTH && key_blocked_i) begin
      chk_sw = SW_BLOCKED;
    end else if (access_condition_i == ACCESS_KEY_AUTH && !key_authenticated_condition_i) begin
      chk_sw = SW_ACFAIL;
    end else if (ins_q == INS_REC) begin
      // Record modes beyond 04 are a parameter error
      if (p2_q > P2_ABS || (p2_q != P2_ABS && p1_q != 8'h00)) begin
        chk_sw = SW_OFFSET;
      end
    end else if (le_q < LE_MIN || le_q > LE_MAX || le_q[2:0] != 3'h0) begin
      chk_sw = SW_LEN;
    end else if (offset >= file_size_i) begin
      chk_sw = SW_OFFSET;
    end else if (end_addr > {1'b0, file_size_i}) begin
      chk_sw = SW_LEN;
    end else if (usb_mode_i && usb_xfer_len_i != le_q) begin
      chk_sw = {SW1_WRONGLE, le_q};
    end
    if (fault_i) begin
      chk_sw = SW_FAULT;
    end
    chk_fail = (chk_sw != SW_OK);
  end

  // Byte handed to the response buffer is the block's top byte
  assign fifo_valid = (s_q.st == ST_PUSH);

  // Sequencer next state
  always_comb begin
    s_d        = s_q;
    s_d.swv    = 1'b0;
    s_d.cstart = 1'b0;
    s_d.rst    = 1'b0;
    s_d.rdy    = 1'b0;
    // Key nibble follows the selected file at all times
    s_d.dkey   = create_byte10_i[KEY_MSB:KEY_LSB];
    case (s_q.st)
      ST_IDLE: begin
        s_d.rdy = 1'b1;
        if (cmd_valid_i && s_q.rdy) begin
          // Header bytes are captured with the command
          s_d.cla = cmd_cla_i;
          s_d.ins = cmd_ins_i;
          s_d.p1  = cmd_p1_i;
          s_d.p2  = cmd_p2_i;
          s_d.le  = cmd_le_i;
          s_d.st  = ST_CHECK;
          s_d.rdy = 1'b0;
        end
      end
      ST_CHECK: begin
        s_d.addr = offset;
        s_d.left = le_q;
        s_d.idx  = 3'h0;
        s_d.ph   = 2'h0;
        s_d.key  = create_byte10_i[KEY_MSB:KEY_LSB];
        if (chk_fail) begin
          // Refusals carry no data
          s_d.sw = chk_sw;
          s_d.st = ST_STATUS;
        end else if (ins_q == INS_REC) begin
          // Record fetch belongs to the record handler
          s_d.rst   = 1'b1;
          s_d.rabs  = (p2_q == P2_ABS);
          s_d.rmode = (p2_q <= P2_CUR_MAX) ? p2_q[1:0] : 2'h0;
          s_d.rnum  = p1_q;
          s_d.st    = ST_IDLE;
        end else begin
          s_d.sw = SW_OK;
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Three phases: strobe, wait, capture
        case (s_q.ph)
          2'h0: begin
            s_d.rd = 1'b1;
            s_d.ph = 2'h1;
          end
          2'h1: begin
            s_d.rd = 1'b0;
            s_d.ph = 2'h2;
          end
          default: begin
            s_d.blk  = {s_q.blk[55:0], mem_rdata_i};
            s_d.addr = s_q.addr + 16'h0001;
            s_d.idx  = s_q.idx + 3'h1;
            s_d.ph   = 2'h0;
            if (s_q.idx == BLK_LAST) begin
              s_d.cstart = 1'b1;
              s_d.st     = ST_CIPHER;
            end
          end
        endcase
        if (fault_i) begin
          // Partial data already queued still drains
          s_d.rd = 1'b0;
          s_d.sw = SW_FAULT;
          s_d.st = ST_DRAIN;
        end
      end
      ST_CIPHER: begin
        if (ciph_done_i) begin
          s_d.blk = ciph_result_i;
          s_d.idx = 3'h0;
          s_d.st  = ST_PUSH;
        end
        if (fault_i) begin
          s_d.sw = SW_FAULT;
          s_d.st = ST_DRAIN;
        end
      end
      ST_PUSH: begin
        // Back-pressure from the buffer stalls here
        if (fifo_ready) begin
          s_d.blk = {s_q.blk[55:0], 8'h00};
          s_d.idx = s_q.idx + 3'h1;
          if (s_q.idx == BLK_LAST) begin
            s_d.left = s_q.left - 8'(BLK_BYTES);
            s_d.st   = (s_q.left == 8'(BLK_BYTES)) ? ST_DRAIN : ST_FETCH;
          end
        end
      end
      ST_DRAIN: begin
        // Status only after the last data byte left
        if (!fifo_out_v) begin
          s_d.st = ST_STATUS;
        end
      end
      ST_STATUS: begin
        s_d.swv = 1'b1;
        s_d.st  = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q    <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Response buffer between cipher and host stream
  ebr_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (fifo_valid),
    .in_data_i   (s_q.blk[63:56]),
    .in_ready_o  (fifo_ready),
    .out_valid_o (fifo_out_v),
    .out_data_o  (resp_data_o),
    .out_ready_i (resp_ready_i)
  );

  // Outputs
  assign resp_valid_o   = fifo_out_v;
  assign cmd_ready_o    = s_q.rdy;
  assign dir_key_num_o  = s_q.dkey;
  assign mem_rd_o       = s_q.rd;
  assign mem_addr_o     = s_q.addr;
  assign ciph_start_o   = s_q.cstart;
  assign ciph_key_num_o = s_q.key;
  assign ciph_block_o   = s_q.blk;
  assign sw_valid_o     = s_q.swv;
  assign sw_o           = s_q.sw;
  assign rec_start_o    = s_q.rst;
  assign rec_absolute_o = s_q.rabs;
  assign rec_cur_mode_o = s_q.rmode;
  assign rec_number_o   = s_q.rnum;
endmodule

/* dv/ebr_cmd_sva.sv */
`timescale 1ns/1ps
// Pin-level watch on the command handler
module ebr_cmd_sva
  import ebr_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // Command and file context
  input wire logic        cmd_valid_i,
  input wire logic [7:0]  cmd_cla_i,
  input wire logic [7:0]  cmd_ins_i,
  input wire logic [7:0]  cmd_le_i,
  input wire logic        cmd_ready_o,
  input wire logic [1:0]  file_type_i,
  input wire logic        file_invalid_i,
  input wire logic [1:0]  access_condition_i,
  input wire logic [7:0]  create_byte10_i,
  input wire logic        fault_i,
  // Results
  input wire logic [3:0]  dir_key_num_o,
  input wire logic        mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic        ciph_start_o,
  input wire logic [3:0]  ciph_key_num_o,
  input wire logic        sw_valid_o,
  input wire logic [15:0] sw_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic       tk;   // Header taken; fault kept out as it overrides all
  logic       enc;  // Enciphered read taken
  logic       trok; // Same, on a valid transparent file
  logic [3:0] nib;  // Key nibble of the creation byte
  assign tk   = cmd_valid_i && cmd_ready_o && !fault_i;
  assign enc  = tk && cmd_cla_i == CLA_ENC && cmd_ins_i == INS_BIN;
  assign trok = enc && file_type_i == FILE_TRANSP && !file_invalid_i;
  assign nib  = create_byte10_i[KEY_MSB:KEY_LSB];
  cla_bad_a: assert property (tk && cmd_cla_i != CLA_ENC && cmd_cla_i != CLA_REC
    |-> ##[3:4] sw_valid_o && sw_o == SW_CLA) else $error("class refusal wrong");
  ins_bad_a: assert property (tk && cmd_cla_i == CLA_ENC && cmd_ins_i != INS_BIN && cmd_ins_i != INS_REC
    |-> ##[3:4] sw_valid_o && sw_o == SW_INS) else $error("instruction refusal wrong");
  df_sel_a: assert property (enc && file_type_i == FILE_DF
    |-> ##[3:4] sw_valid_o && sw_o == SW_DFSEL) else $error("directory refusal wrong");
  rec_file_a: assert property (enc && file_type_i[1]
    |-> ##[3:4] sw_valid_o && sw_o == SW_WRONGEF) else $error("record file refusal wrong");
  inval_file_a: assert property (enc && file_type_i == FILE_TRANSP && file_invalid_i
    |-> ##[3:4] sw_valid_o && sw_o == SW_INVAL) else $error("invalid file refusal wrong");
  prot_mode_a: assert property (trok && access_condition_i == ACCESS_PROT
    |-> ##[3:4] sw_valid_o && sw_o == SW_ACFAIL) else $error("protected mode accepted");
  len_gran_a: assert property (trok && access_condition_i == ACCESS_ALWAYS && cmd_le_i[2:0] != 3'h0
    |-> ##[3:4] sw_valid_o && sw_o == SW_LEN) else $error("length refusal wrong");
  key_sel_a: assert property (ciph_start_o |-> ciph_key_num_o == nib)
    else $error("cipher key number wrong");
  dir_key_a: assert property (!rst_i |=> dir_key_num_o == $past(nib))
    else $error("directory key number wrong");
  byte_step_a: assert property (mem_rd_o ##3 mem_rd_o |-> mem_addr_o == $past(mem_addr_o, 3) + 16'h0001)
    else $error("fetch address step wrong");
endmodule

bind ebr_cmd ebr_cmd_sva i_sva (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_cla_i(cmd_cla_i), .cmd_ins_i(cmd_ins_i), .cmd_le_i(cmd_le_i), .cmd_ready_o(cmd_ready_o),
  .file_type_i(file_type_i), .file_invalid_i(file_invalid_i), .access_condition_i(access_condition_i),
  .create_byte10_i(create_byte10_i), .fault_i(fault_i), .dir_key_num_o(dir_key_num_o), .mem_rd_o(mem_rd_o),
  .mem_addr_o(mem_addr_o), .ciph_start_o(ciph_start_o), .ciph_key_num_o(ciph_key_num_o),
  .sw_valid_o(sw_valid_o), .sw_o(sw_o));

/* dv/ebr_far_model.sv */
`timescale 1ns/1ps
// File memory and cipher engine behind the handler
module ebr_far_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Cipher pace
  input  wire logic        slow_i,
  // File memory
  input  wire logic        mem_rd_i,
  input  wire logic [15:0] mem_addr_i,
  output logic [7:0]       mem_rdata_o,
  // Cipher engine
  input  wire logic        ciph_start_i,
  input  wire logic [3:0]  ciph_key_num_i,
  input  wire logic [63:0] ciph_block_i,
  output logic             ciph_done_o,
  output logic [63:0]      ciph_result_o
);
  logic [7:0]  dat_q; // Read data
  logic [63:0] res_q; // Enciphered block
  logic [4:0]  cnt_q; // Cipher latency
  // Data good one cycle only; flips after so stale use shows
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      dat_q <= 8'h00;
    end else begin
      dat_q <= mem_rd_i ? (mem_addr_i[7:0] ^ mem_addr_i[15:8] ^ 8'h5A) : ~dat_q;
    end
  end
  // Stand-in cipher, keyed so a wrong key number shows in the data
  always @(posedge core_clk_i) begin
    ciph_done_o <= 1'b0;
    if (rst_i) begin
      cnt_q <= 5'h00;
      res_q <= 64'h0000_0000_0000_0000;
    end else if (ciph_start_i) begin
      res_q <= ~ciph_block_i ^ {16{ciph_key_num_i}};
      cnt_q <= slow_i ? 5'h14 : 5'h01;
    end else if (cnt_q != 5'h00) begin
      cnt_q       <= cnt_q - 5'h01;
      ciph_done_o <= cnt_q == 5'h01;
    end
  end
  assign mem_rdata_o   = dat_q;
  assign ciph_result_o = ciph_done_o ? res_q : ~res_q;
endmodule

/* dv/ebr_cmd_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the enciphered read handler
module ebr_cmd_tb;
  import ebr_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic [11:0] ctx        = 12'h470;          // Type, invalid, access, keys, fault, usb
  logic [39:0] hdr        = 40'h00_0000_0000; // Class, ins, P1, P2, Le
  logic        cmd_valid  = 1'b0;
  logic        resp_ready = 1'b1;
  logic        slow       = 1'b0;
  logic [7:0]  xfer_len   = 8'h10;
  logic [7:0]  cbyte      = 8'hA5;
  logic [15:0] fsize      = 16'h0120;         // Selected file length
  logic [7:0]  le_r;
  logic [10:0] re;
  logic [31:0] seed       = 32'h0001_1A63;
  logic [31:0] rseed      = 32'h0001_1A63;
  int          stall_n    = 0;
  int          cycles     = 0;
  int          bad_count  = 0;
  int          n_compared = 0;
  logic [15:0] exp_sw[$];  // Noted status words
  logic [7:0]  exp_dat[$]; // Noted data bytes
  logic [10:0] exp_rec[$]; // Noted record hand-offs
  // Handler to far side and bench
  logic        mem_rd, ciph_start, ciph_done, resp_valid, sw_valid, cmd_ready, rec_start, rec_abs;
  logic [15:0] mem_addr, sw;
  logic [7:0]  mem_rdata, resp_data, rec_num;
  logic [3:0]  dir_key, ckey;
  logic [63:0] cblk, cres;
  logic [1:0]  rec_mode;
  ebr_cmd i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_cla_i(hdr[39:32]),
    .cmd_ins_i(hdr[31:24]), .cmd_p1_i(hdr[23:16]), .cmd_p2_i(hdr[15:8]), .cmd_le_i(hdr[7:0]),
    .cmd_ready_o(cmd_ready), .usb_mode_i(ctx[1]), .usb_xfer_len_i(xfer_len), .file_type_i(ctx[11:10]),
    .file_invalid_i(ctx[9]), .file_size_i(fsize), .access_condition_i(ctx[8:7]), .create_byte10_i(cbyte),
    .key_file_present_i(ctx[6]), .key_present_i(ctx[5]), .key_authenticated_condition_i(ctx[4]),
    .key_blocked_i(ctx[3]), .fault_i(ctx[2]), .dir_key_num_o(dir_key), .mem_rd_o(mem_rd),
    .mem_addr_o(mem_addr), .mem_rdata_i(mem_rdata), .ciph_start_o(ciph_start), .ciph_key_num_o(ckey),
    .ciph_block_o(cblk), .ciph_done_i(ciph_done), .ciph_result_i(cres), .resp_valid_o(resp_valid),
    .resp_data_o(resp_data), .resp_ready_i(resp_ready), .sw_valid_o(sw_valid), .sw_o(sw),
    .rec_start_o(rec_start), .rec_absolute_o(rec_abs), .rec_cur_mode_o(rec_mode), .rec_number_o(rec_num));
  ebr_far_model i_far (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .mem_rd_i(mem_rd),
    .mem_addr_i(mem_addr), .mem_rdata_o(mem_rdata), .ciph_start_i(ciph_start), .ciph_key_num_i(ckey),
    .ciph_block_i(cblk), .ciph_done_o(ciph_done), .ciph_result_o(cres));
  always #25 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Random back-pressure, held off during a stall; hang guard
  always @(posedge core_clk_i) begin
    #2;
    cycles++;
    seed = xs(seed);
    if (stall_n > 0) stall_n--;
    resp_ready = stall_n == 0 && seed[1:0] != 2'b00;
    if (cycles > 30000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Watcher: oldest note against each result
  always @(posedge core_clk_i) begin
    if (resp_valid === 1'b1 && resp_ready)
      cmp(exp_dat.size() > 0 ? {8'h00, exp_dat.pop_front()} : 16'hxxxx, {8'h00, resp_data});
    if (sw_valid === 1'b1) cmp(exp_sw.size() > 0 ? exp_sw.pop_front() : 16'hxxxx, sw);
    if (rec_start === 1'b1) begin
      re = exp_rec.size() > 0 ? exp_rec.pop_front() : 11'h7FF;
      cmp({5'h00, re}, {5'h00, rec_abs, re[10] ? 2'b00 : rec_mode, re[10] ? rec_num : 8'h00});
    end
  end
  task automatic idle();
    for (int k = 0; k < 3000 && cmd_ready !== 1'b1; k++) begin
      @(posedge core_clk_i);
      #2;
    end
  endtask
  // One command; status 0000 notes a record hand-off instead
  task automatic go(input logic [11:0] c, input logic [39:0] h, input logic [15:0] e);
    idle();
    ctx = c;
    hdr = h;
    if (e != 16'h0000) exp_sw.push_back(e);
    else exp_rec.push_back(h[15:8] == P2_ABS ? {3'b100, h[23:16]} : {1'b0, h[9:8], 8'h00});
    cmd_valid = 1'b1;
    @(posedge core_clk_i);
    #2;
    cmd_valid = 1'b0;
    idle();
  endtask
  // Good read: every byte noted in file order, then 9000
  task automatic rd(input logic [15:0] off, input logic [7:0] le);
    logic [15:0] a;
    for (int i = 0; i < le; i++) begin
      a = off + 16'(i);
      exp_dat.push_back(~(a[7:0] ^ a[15:8] ^ 8'h5A) ^ {2{cbyte[7:4]}});
    end
    go(12'h470, {CLA_ENC, INS_BIN, off, le}, SW_OK);
    cmp({12'h000, cbyte[7:4]}, {12'h000, dir_key});
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    #2;
    rst_i = 1'b0;
    go(12'h470, 40'h00_B000_0008, SW_CLA);
    go(12'h470, 40'hC0_B000_0008, SW_CLA);
    go(12'h470, 40'h04_1000_0008, SW_INS);
    go(12'h070, 40'h04_B000_0008, SW_DFSEL);
    go(12'h870, 40'h04_B000_0008, SW_WRONGEF);
    go(12'hC70, 40'h04_B000_0008, SW_WRONGEF);
    go(12'h670, 40'h04_B000_0008, SW_INVAL);
    go(12'h7F0, 40'h04_B000_0008, SW_INVAL);
    go(12'h5F0, 40'h04_B000_0008, SW_ACFAIL);
    go(12'h4F0, 40'h04_B000_0008, SW_ACFAIL);
    go(12'h530, 40'h04_B000_0008, SW_NOKEY);
    go(12'h578, 40'h04_B000_0008, SW_BLOCKED);
    go(12'h560, 40'h04_B000_0008, SW_ACFAIL);
    go(12'h470, 40'h04_B000_000C, SW_LEN);
    go(12'h470, 40'h04_B000_00F0, SW_LEN);
    go(12'h470, 40'h04_B001_2008, SW_OFFSET);
    go(12'h470, 40'h04_B001_1810, SW_LEN);
    fsize = 16'h0010;
    go(12'h470, 40'h04_B000_1008, SW_OFFSET);
    go(12'h470, 40'h04_B000_0810, SW_LEN);
    fsize = 16'h0120;
    go(12'h474, 40'h04_B000_0008, SW_FAULT);
    go(12'h472, 40'h04_B000_0008, {SW1_WRONGLE, 8'h08});
    go(12'h470, 40'hC0_B200_0408, SW_WRONGEF);
    go(12'hA70, 40'hC0_B200_0408, SW_INVAL);
    go(12'hC70, 40'hC0_B201_0108, SW_OFFSET);
    go(12'h870, 40'hC0_B203_0408, 16'h0000);
    go(12'hC70, 40'hC0_B200_0208, 16'h0000);
    rd(16'h0000, 8'h08);
    rd(16'h0105, 8'h10);
    slow = 1'b1;
    stall_n = 200;
    rd(16'h0038, 8'hE8);
    for (int n = 0; n < 6; n++) begin
      rseed = xs(rseed);
      cbyte = rseed[7:0];
      slow = rseed[8];
      le_r = 8'((int'(rseed[13:9]) % 29 + 1) * 8);
      rd(16'(int'(rseed[31:16]) % (289 - int'(le_r))), le_r);
    end
    repeat (20) @(posedge core_clk_i);
    cmp(16'h0000, 16'(exp_dat.size() + exp_sw.size() + exp_rec.size()));
    end_of_test();
  end
endmodule
